// ==== bts_pkg.sv ====
// Constants and types for the branch trace store control block
//------------------------------------------------------------------
// Contract
// - Branch messages only while the message enable bit 6 is set.
// - Enabled messages go on the bus, or to memory when bit 7 set.
// - A message never goes both to the bus and to memory.
// - Bit 8 set raises interrupt as buffer fills; clear means circular.
// - Message enable clear disables messages whatever else is set.
// - All three enables set: store and interrupt near full.
// - Software programs base, index, maximum, threshold; device uses them.
// - Store interrupt whenever index reaches or passes the threshold; code needs bits 6 and 7 set and not both skips.
// - Skip kernel only: store records at privilege above zero.
// - Skip user only: store records at privilege zero.
// - Both skips set: messages generated, nothing stored.
// - Store and both sampling interrupts share one vector.
// - Non-circular full buffer leaves storing enabled.
// - Device masks the monitor interrupt on delivery; handler unmasks.
// - Recent-branch log bit 0 keeps the record stack running.
// - Step-on-branch bit 1 makes single step act on branches.
// - Eight stack entries, source in 31-0, destination in 63-32.
// - Three-bit newest-record pointer in bits 2-0.
// - Debug exception under step-on-branch clears both step flags.
//------------------------------------------------------------------
package bts_pkg;
  // Register offsets
  localparam logic [11:0] OFS_ENTRY0   = 12'h040;
  localparam logic [11:0] OFS_POINTER  = 12'h1C9;
  localparam logic [11:0] OFS_DBGCTL   = 12'h1D9;
  localparam logic [11:0] OFS_BASE     = 12'h300;
  localparam logic [11:0] OFS_INDEX    = 12'h301;
  localparam logic [11:0] OFS_ABSMAX   = 12'h302;
  localparam logic [11:0] OFS_THRESH   = 12'h303;
  localparam logic [11:0] OFS_STATUS   = 12'h304;
  localparam logic [11:0] OFS_LER_SRC  = 12'h305;
  localparam logic [11:0] OFS_LER_DST  = 12'h306;
  localparam logic [11:0] OFS_STEP     = 12'h307;
  localparam logic [11:0] OFS_VECTOR   = 12'h308;
  // Control field positions
  localparam int BIT_LOG      = 0;
  localparam int BIT_STEP_BR  = 1;
  localparam int BIT_MSG      = 6;
  localparam int BIT_STORE    = 7;
  localparam int BIT_FULL_IRQ = 8;
  localparam int BIT_SKIP_K   = 9;
  localparam int BIT_SKIP_U   = 10;
  localparam logic [10:0] DBGCTL_WMASK = 11'h7C3;
  // Reset values and record geometry
  localparam logic [10:0] DBGCTL_RST   = 11'h000;
  localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
  localparam logic [31:0] REC_BYTES    = 32'h0000_0008;
  localparam int          STACK_DEPTH  = 8;
  // Event kinds
  typedef enum logic [1:0] {BTS_BRANCH, BTS_IRQ, BTS_EXC} bts_kind_t;
endpackage

// ==== bts_core.sv ====
// Branch trace store, record stack and step control in one module
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
module bts_core
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [63:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [63:0] rd_data_out,
  input  wire logic        event_valid_in,
  input  wire logic [1:0]  event_kind_in,
  input  wire logic [31:0] event_src_in,
  input  wire logic [31:0] event_dst_in,
  input  wire logic [1:0]  privilege_level_in,
  input  wire logic        insn_retire_in,
  input  wire logic        nonprecise_irq_in,
  input  wire logic        precise_irq_in,
  output logic             msg_valid_out,
  output logic      [63:0] msg_data_out,
  output logic             mem_wr_out,
  output logic      [31:0] mem_addr_out,
  output logic      [63:0] mem_data_out,
  output logic             perf_irq_out,
  output logic             debug_exc_out
);

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    logic [10:0]      dbgctl;
    logic             single_step;
    logic [31:0]      base;
    logic [31:0]      index;
    logic [31:0]      absmax;
    logic [31:0]      thresh;
    logic [7:0][63:0] stack;
    logic [2:0]       pointer;
    logic [31:0]      ler_src;
    logic [31:0]      ler_dst;
    logic [63:0]      last_branch;
    logic             vec_mask;
    logic             msg_valid;
    logic [63:0]      msg_data;
    logic             mem_wr;
    logic [31:0]      mem_addr;
    logic [63:0]      mem_data;
    logic             irq;
    logic             dbg_exc;
    logic [63:0]      rdata;
  } bts_state_t;

  bts_state_t s_ff;
  bts_state_t nxt_s;

  logic        trace_on;
  logic        store_on;
  logic        skip_k;
  logic        skip_u;
  logic        kept;
  logic        do_store;
  logic        do_msg;
  logic        room;
  logic        thr_hit;
  logic [31:0] next_index;
  logic [2:0]  nxt_ptr;
  logic [63:0] record;

  //----------------------------------------------------------------
  // Routing decisions for the incoming event
  //----------------------------------------------------------------
  // Control bits decoded once so every path agrees on the target
  assign trace_on = s_ff.dbgctl[bts_pkg::BIT_MSG];
  assign store_on = trace_on & s_ff.dbgctl[bts_pkg::BIT_STORE];
  assign skip_k   = s_ff.dbgctl[bts_pkg::BIT_SKIP_K];
  assign skip_u   = s_ff.dbgctl[bts_pkg::BIT_SKIP_U];
  // Kernel is privilege zero; both skips drop everything
  assign kept = !(skip_k && privilege_level_in == 2'h0) &&
                !(skip_u && privilege_level_in != 2'h0);
  assign do_store = event_valid_in & store_on & kept;
  // Bus only when not storing; a record dropped by one skip goes nowhere
  assign do_msg = event_valid_in & trace_on &
                  (~s_ff.dbgctl[bts_pkg::BIT_STORE] |
                   (skip_k & skip_u));
  assign record = {event_dst_in, event_src_in};
  assign nxt_ptr = s_ff.pointer + 3'h1;
  assign next_index = s_ff.index + bts_pkg::REC_BYTES;
  // A full non-circular buffer drops records rather than overrun
  assign room = (next_index <= s_ff.absmax) |
                ~s_ff.dbgctl[bts_pkg::BIT_FULL_IRQ];
  // Threshold test ignores the full-interrupt bit on purpose
  assign thr_hit = store_on & ~(skip_k & skip_u) &
                   (s_ff.index >= s_ff.thresh);

  //----------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.msg_valid = 1'b0;
    nxt_s.mem_wr = 1'b0;
    nxt_s.irq = 1'b0;
    nxt_s.dbg_exc = 1'b0;
    nxt_s.rdata = 64'h0000_0000_0000_0000;

    // Register reads, answered one cycle later
    if (rd_en_in)
    begin
      if (addr_in[11:3] == bts_pkg::OFS_ENTRY0[11:3])
        nxt_s.rdata = s_ff.stack[addr_in[2:0]];
      else if (addr_in == bts_pkg::OFS_POINTER)
        nxt_s.rdata = {61'h0, s_ff.pointer};
      else if (addr_in == bts_pkg::OFS_DBGCTL)
        nxt_s.rdata = {53'h0, s_ff.dbgctl};
      else if (addr_in == bts_pkg::OFS_BASE)
        nxt_s.rdata = {32'h0, s_ff.base};
      else if (addr_in == bts_pkg::OFS_INDEX)
        nxt_s.rdata = {32'h0, s_ff.index};
      else if (addr_in == bts_pkg::OFS_ABSMAX)
        nxt_s.rdata = {32'h0, s_ff.absmax};
      else if (addr_in == bts_pkg::OFS_THRESH)
        nxt_s.rdata = {32'h0, s_ff.thresh};
      else if (addr_in == bts_pkg::OFS_STATUS)
        nxt_s.rdata = {61'h0, precise_irq_in, nonprecise_irq_in,
                       thr_hit};
      else if (addr_in == bts_pkg::OFS_LER_SRC)
        nxt_s.rdata = {32'h0, s_ff.ler_src};
      else if (addr_in == bts_pkg::OFS_LER_DST)
        nxt_s.rdata = {32'h0, s_ff.ler_dst};
      else if (addr_in == bts_pkg::OFS_STEP)
        nxt_s.rdata = {63'h0, s_ff.single_step};
      else if (addr_in == bts_pkg::OFS_VECTOR)
        nxt_s.rdata = {63'h0, s_ff.vec_mask};
      else
        nxt_s.rdata = 64'h0000_0000_0000_0000;
    end

    // Register writes; the stack and pointer are read only
    if (wr_en_in)
    begin
      if (addr_in == bts_pkg::OFS_DBGCTL)
        nxt_s.dbgctl = wr_data_in[10:0] & bts_pkg::DBGCTL_WMASK;
      else if (addr_in == bts_pkg::OFS_BASE)
        nxt_s.base = wr_data_in[31:0];
      else if (addr_in == bts_pkg::OFS_INDEX)
        nxt_s.index = wr_data_in[31:0];
      else if (addr_in == bts_pkg::OFS_ABSMAX)
        nxt_s.absmax = wr_data_in[31:0];
      else if (addr_in == bts_pkg::OFS_THRESH)
        nxt_s.thresh = wr_data_in[31:0];
      else if (addr_in == bts_pkg::OFS_STEP)
        nxt_s.single_step = wr_data_in[0];
      else if (addr_in == bts_pkg::OFS_VECTOR)
        nxt_s.vec_mask = wr_data_in[0];
    end

    // Bus message path
    if (do_msg)
    begin
      nxt_s.msg_valid = 1'b1;
      nxt_s.msg_data = record;
    end

    // Memory store path; event update wins over a same-cycle write
    if (do_store && room)
    begin
      nxt_s.mem_wr = 1'b1;
      nxt_s.mem_addr = s_ff.index;
      if (!s_ff.dbgctl[bts_pkg::BIT_FULL_IRQ] &&
          next_index >= s_ff.absmax)
        nxt_s.index = s_ff.base;
      else
        nxt_s.index = next_index;
      nxt_s.mem_data = record;
    end

    // Record stack keeps running while message generation needs it
    if (event_valid_in &&
        (s_ff.dbgctl[bts_pkg::BIT_LOG] || trace_on))
    begin
      nxt_s.pointer = nxt_ptr;
      nxt_s.stack[nxt_ptr] = record;
    end

    // Last exception record holds the branch taken before it
    if (event_valid_in)
    begin
      if (event_kind_in == bts_pkg::BTS_BRANCH)
        nxt_s.last_branch = record;
      else
      begin
        nxt_s.ler_src = s_ff.last_branch[31:0];
        nxt_s.ler_dst = s_ff.last_branch[63:32];
      end
    end

    // Single step, on control transfers or on instructions
    if (s_ff.single_step)
    begin
      if (s_ff.dbgctl[bts_pkg::BIT_STEP_BR] && event_valid_in)
      begin
        nxt_s.dbg_exc = 1'b1;
        nxt_s.single_step = 1'b0;
        nxt_s.dbgctl[bts_pkg::BIT_STEP_BR] = 1'b0;
      end
      else if (!s_ff.dbgctl[bts_pkg::BIT_STEP_BR] && insn_retire_in)
        nxt_s.dbg_exc = 1'b1;
    end

    // Shared vector: one pulse, then masked until software unmasks
    if ((thr_hit || nonprecise_irq_in || precise_irq_in) &&
        !s_ff.vec_mask)
    begin
      nxt_s.irq = 1'b1;
      nxt_s.vec_mask = 1'b1;
    end
  end

  //----------------------------------------------------------------
  // State register
  //----------------------------------------------------------------
  // Stack contents reset to zero so reads are never unknown
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      s_ff <= '0;
      s_ff.dbgctl <= bts_pkg::DBGCTL_RST;
      s_ff.base <= bts_pkg::ADDR_RST;
      s_ff.index <= bts_pkg::ADDR_RST;
      s_ff.absmax <= bts_pkg::ADDR_RST;
      s_ff.thresh <= bts_pkg::ADDR_RST;
    end
    else
      s_ff <= nxt_s;
  end

  //----------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------
  assign rd_data_out   = s_ff.rdata;
  assign msg_valid_out = s_ff.msg_valid;
  assign msg_data_out  = s_ff.msg_data;
  assign mem_wr_out    = s_ff.mem_wr;
  assign mem_addr_out  = s_ff.mem_addr;
  assign mem_data_out  = s_ff.mem_data;
  assign perf_irq_out  = s_ff.irq;
  assign debug_exc_out = s_ff.dbg_exc;

endmodule

// ==== bts_core_asserts.sv ====
// Port-level assertions for the branch trace store block
`timescale 1ns/10ps
module bts_core_asserts
(
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [11:0] addr_in,
  input wire logic [63:0] wr_data_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [63:0] rd_data_out,
  input wire logic        event_valid_in,
  input wire logic [31:0] event_src_in,
  input wire logic [31:0] event_dst_in,
  input wire logic [1:0]  privilege_level_in,
  input wire logic        insn_retire_in,
  input wire logic        msg_valid_out,
  input wire logic [63:0] msg_data_out,
  input wire logic        mem_wr_out,
  input wire logic [63:0] mem_data_out,
  input wire logic        perf_irq_out,
  input wire logic        debug_exc_out
);
  //------------------------------------------------------------
  // Control shadow, rebuilt from register writes
  //------------------------------------------------------------
  logic [10:0] ctl_ff;
  logic        sto_ok;
  // Step bit may be cleared by the block; only bits 6-10 are used here
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      ctl_ff <= bts_pkg::DBGCTL_RST;
    else if (wr_en_in && addr_in == bts_pkg::OFS_DBGCTL)
      ctl_ff <= wr_data_in[10:0] & bts_pkg::DBGCTL_WMASK;
  end
  // Record passes both privilege filters with storing on
  assign sto_ok = ctl_ff[6] & ctl_ff[7]
                  & !(ctl_ff[9] & privilege_level_in == 2'h0)
                  & !(ctl_ff[10] & privilege_level_in != 2'h0);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_excl; !(msg_valid_out && mem_wr_out); endproperty
  a_excl: assert property (p_excl) else $error("bus and store");
  property p_off;
    event_valid_in && !ctl_ff[6] |=> !msg_valid_out && !mem_wr_out;
  endproperty
  a_off: assert property (p_off) else $error("output while off");
  property p_bus;
    event_valid_in && ctl_ff[6] && (!ctl_ff[7] || ctl_ff[10:9] == 2'h3)
    |=> msg_valid_out;
  endproperty
  a_bus: assert property (p_bus) else $error("bus message lost");
  property p_store; mem_wr_out |-> $past(event_valid_in && sto_ok); endproperty
  a_store: assert property (p_store) else $error("bad store");
  property p_msg_data;
    msg_valid_out |-> msg_data_out == {$past(event_dst_in), $past(event_src_in)};
  endproperty
  a_msg_data: assert property (p_msg_data) else $error("msg data");
  property p_mem_data;
    mem_wr_out |-> mem_data_out == {$past(event_dst_in), $past(event_src_in)};
  endproperty
  a_mem_data: assert property (p_mem_data) else $error("mem data");
  property p_step; debug_exc_out |-> $past(event_valid_in || insn_retire_in);
  endproperty
  a_step: assert property (p_step) else $error("stray step trap");
  property p_step_clr; debug_exc_out ##1 !wr_en_in |=> !debug_exc_out;
  endproperty
  a_step_clr: assert property (p_step_clr) else $error("step kept");
  property p_mask; perf_irq_out ##1 !wr_en_in |=> !perf_irq_out; endproperty
  a_mask: assert property (p_mask) else $error("irq not masked");
  property p_ptr;
    rd_en_in && addr_in == bts_pkg::OFS_POINTER |=> rd_data_out[63:3] == 61'h0;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer too wide");
endmodule

// ==== bts_trace_mem.sv ====
// Memory-resident trace buffer that takes the block's record writes
`timescale 1ns/10ps
module bts_trace_mem
(
  input wire logic        clk_in,
  input wire logic        mem_wr_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [63:0] mem_data_in
);
  // Sparse store: only written records exist, so stale reads stand out
  logic [63:0] mem [logic [31:0]];
  always @(posedge clk_in)
  begin
    if (mem_wr_in)
      mem[mem_addr_in] = mem_data_in;
  end
endmodule

// ==== bts_core_test.sv ====
// Self-checking bench for the branch trace store block
`timescale 1ns/10ps
module bts_core_test;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [11:0] addr_in = 12'h000;
  logic [63:0] wr_data_in = 64'h0;
  logic        wr_en_in = 1'b0;
  logic        rd_en_in = 1'b0;
  logic        event_valid_in = 1'b0;
  logic [1:0]  event_kind_in = 2'h0;
  logic [31:0] event_src_in = 32'h0;
  logic [31:0] event_dst_in = 32'h0;
  logic [1:0]  privilege_level_in = 2'h0;
  logic [63:0] rd_data_out, msg_data_out, mem_data_out;
  logic [31:0] mem_addr_out;
  logic        msg_valid_out, mem_wr_out, perf_irq_out, debug_exc_out;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  // Model of control, buffer index, record stack and vector mask
  logic [31:0] seed = 32'h65880807;
  logic [31:0] idx, thr;
  logic [10:0] ctl;
  logic [63:0] stack [8] = '{default: 64'h0};
  logic [2:0]  newest_record_pointer = 3'h0;
  logic        mask, step;
  logic [10:0] modes [9] = '{11'h000, 11'h180, 11'h040, 11'h0C0, 11'h1C0,
                             11'h2C0, 11'h4C0, 11'h6C0, 11'h7C1};
  bts_core bts_core_i (.clk_in, .sys_rst_in, .addr_in, .wr_data_in,
    .wr_en_in, .rd_en_in, .rd_data_out, .event_valid_in, .event_kind_in,
    .event_src_in, .event_dst_in, .privilege_level_in, .insn_retire_in(1'b0),
    .nonprecise_irq_in(1'b0), .precise_irq_in(1'b0), .msg_valid_out,
    .msg_data_out, .mem_wr_out, .mem_addr_out, .mem_data_out, .perf_irq_out,
    .debug_exc_out);
  bts_trace_mem bts_trace_mem_i (.clk_in, .mem_wr_in(mem_wr_out),
    .mem_addr_in(mem_addr_out), .mem_data_in(mem_data_out));
  always #4 clk_in = ~clk_in;
  // Hang guard, far above the roughly 390 cycles the run needs
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge clk_in);
    wr_en_in   <= 1'b1;
    addr_in    <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [63:0] exp);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    addr_in  <= a;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    @(negedge clk_in);
    chk(rd_data_out, exp);
  endtask
  // One random event; the interrupt pulse stands two cycles after it
  task automatic ev();
    logic [63:0] rec;
    logic [31:0] a;
    logic        st, ms, hit, e;
    seed = lfsr(seed);
    rec[31:0] = seed;
    seed = lfsr(seed);
    rec[63:32] = seed;
    ms = ctl[6] & (!ctl[7] | ctl[10:9] == 2'h3);
    st = ctl[6] & ctl[7] & !(ctl[9] & seed[1:0] == 2'h0)
         & !(ctl[10] & seed[1:0] != 2'h0) & (!ctl[8] | idx + 8 <= 32'h1020);
    e = step & ctl[1];
    @(posedge clk_in);
    event_valid_in     <= 1'b1;
    event_kind_in      <= seed[3] ? 2'h2 : {1'b0, seed[2]};
    event_src_in       <= rec[31:0];
    event_dst_in       <= rec[63:32];
    privilege_level_in <= seed[1:0];
    @(posedge clk_in);
    event_valid_in <= 1'b0;
    @(negedge clk_in);
    chk(msg_valid_out, ms);
    chk(mem_wr_out, st);
    chk(debug_exc_out, e);
    if (ms)
      chk(msg_data_out, rec);
    a = idx;
    if (st)
      chk(mem_addr_out, a);
    step = step ^ e;
    ctl[1] = ctl[1] ^ e;
    newest_record_pointer = newest_record_pointer + (ctl[0] | ctl[6]);
    if (ctl[0] | ctl[6])
      stack[newest_record_pointer] = rec;
    if (st)
      idx = (!ctl[8] && idx + 8 >= 32'h1020) ? 32'h1000 : idx + 8;
    hit = ctl[6] & ctl[7] & ctl[10:9] != 2'h3 & idx >= thr;
    @(negedge clk_in);
    chk(perf_irq_out, hit & !mask);
    mask = mask | hit;
    if (st)
      chk(bts_trace_mem_i.mem[a], rec);
  endtask
  // Main sequence: reset, register checks, nine control modes, stepping
  initial
  begin
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(bts_pkg::OFS_DBGCTL, 64'h0);
    wr(bts_pkg::OFS_POINTER, 64'h5);
    rd(bts_pkg::OFS_POINTER, 64'h0);
    rd(12'h0FF, 64'h0);
    for (int i = 0; i < 9; i++)
    begin
      thr = (i == 3) ? 32'h2000 : 32'h1018;
      wr(bts_pkg::OFS_DBGCTL, 64'h0);
      wr(bts_pkg::OFS_BASE, 64'h1000);
      wr(bts_pkg::OFS_INDEX, 64'h1000);
      wr(bts_pkg::OFS_ABSMAX, 64'h1020);
      wr(bts_pkg::OFS_THRESH, {32'h0, thr});
      wr(bts_pkg::OFS_VECTOR, 64'h0);
      wr(bts_pkg::OFS_DBGCTL, {53'h0, modes[i]});
      ctl = modes[i];
      idx = 32'h1000;
      mask = 1'b0;
      step = 1'b0;
      repeat (6) ev();
      rd(bts_pkg::OFS_INDEX, {32'h0, idx});
      rd(bts_pkg::OFS_POINTER, {61'h0, newest_record_pointer});
      rd(bts_pkg::OFS_ENTRY0 | {9'h000, newest_record_pointer}, stack[newest_record_pointer]);
      rd(bts_pkg::OFS_VECTOR, {63'h0, mask});
    end
    wr(bts_pkg::OFS_DBGCTL, 64'h043);
    wr(bts_pkg::OFS_STEP, 64'h1);
    ctl = 11'h043;
    step = 1'b1;
    repeat (2) ev();
    rd(bts_pkg::OFS_DBGCTL, {53'h0, ctl});
    rd(bts_pkg::OFS_STEP, {63'h0, step});
    print_verdict();
  end
endmodule
bind bts_core bts_core_asserts bts_core_asserts_i (.clk_in, .sys_rst_in,
  .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .event_valid_in,
  .event_src_in, .event_dst_in, .privilege_level_in, .insn_retire_in,
  .msg_valid_out, .msg_data_out, .mem_wr_out, .mem_data_out, .perf_irq_out,
  .debug_exc_out);
